// >>> rtl/fpc_device.sv
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "fpc_cfg.svh"
// Overview of operation
// - x32 ratio: 1 plain, 4 secure, 8 compressed
// - host clock equals ratio times word rate
// - host keeps ratio-1 clocks after last word
// - byte uses lines 7..0, half-word 15..0
// - scheme select picks width and POR delay
// - user mode all high; request low reconfigures
// - status held low for POR delay
// - load complete low until transfer ends
// - load complete released only on good image
// - host sends two falling edges after release
// - clock ignored once in user mode; here user_data and the request synchronizer are still clocked by it
// - data lines become user inputs afterwards
// - init-done pin low from option until done
module fpc_device
#(
    parameter int unsigned POR_SHORT_CYC = `FPC_POR_SHORT_CYC,
    parameter int unsigned POR_LONG_CYC  = `FPC_POR_LONG_CYC
)
(
    fpc_link_if.device_mp   lnk,
    input  wire logic       rst_b,
    input  wire logic [2:0] scheme_select,
    output logic            user_mode,
    output logic [31:0]     user_data,
    output logic            init_done_en,
    output logic            config_error
);
    import fpc_pkg::*;

    logic              req_n_s;
    logic [2:0]        sel_s;
    fpc_dev_state_type state;
    fpc_dev_state_type next_state;
    fpc_width_type     width;
    logic [15:0]       cnt;
    logic [15:0]       beat_cnt;
    logic [3:0]        ratio;
    logic [3:0]        ratio_cnt;
    logic [2:0]        opt;
    logic [31:0]       csum;

    fpc_sync3 #(.W(1), .RST_VAL(1'b1)) u_req_sync
    (
        .clk   (lnk.config_clock),
        .rst_b (rst_b),
        .d     (lnk.reconfig_request_n),
        .q     (req_n_s)
    );

    fpc_sync3 #(.W(3), .RST_VAL(3'h0)) u_sel_sync
    (
        .clk   (lnk.config_clock),
        .rst_b (rst_b),
        .d     (scheme_select),
        .q     (sel_s)
    );

    // unused upper lanes are masked so stray levels never reach the image
    wire [31:0] beat      = lnk.data & fpc_lane_mask(width);
    wire        take      = (ratio_cnt == 4'h0);
    wire [15:0] por_len   = sel_s[2] ? 16'(POR_LONG_CYC - 1) : 16'(POR_SHORT_CYC - 1);
    wire        por_end   = (cnt == por_len);
    wire        last_beat = (beat_cnt == 16'(`FPC_IMAGE_BEATS - 1));
    wire        sync_seen = (beat[7:0] == `FPC_SYNC_BYTE);
    wire        sum_ok    = (beat == csum);
    wire [15:0] tail_end  = {12'h000, ratio} - 16'h0002;
    wire        in_user   = (state == DV_USER);
    wire        released  = (state == DV_RELEASED) || (state == DV_INIT) || in_user;
    wire        init_busy = (state == DV_LOAD) || (state == DV_DONE) ||
                            (state == DV_RELEASED) || (state == DV_INIT);

    always_comb
    begin
        next_state = state;
        case (state)
            DV_POR:
                if (por_end)
                    next_state = DV_WAIT;
            DV_RECONF:
                if (req_n_s)
                    next_state = DV_WAIT;
            DV_WAIT:
                if (sync_seen)
                    next_state = DV_OPTION;
            DV_OPTION:
                next_state = DV_LOAD;
            DV_LOAD:
                if (take && last_beat)
                begin
                    if (!sum_ok)
                        next_state = DV_ERROR;
                    else if (ratio == 4'h1)
                        next_state = DV_RELEASED;
                    else
                        next_state = DV_DONE;
                end
            DV_DONE:
                // the ratio-1 tail clocks finish decrypt and decompress
                if (cnt == tail_end)
                    next_state = DV_RELEASED;
            DV_RELEASED:
                if (cnt == 16'h0001)
                    next_state = DV_INIT;
            DV_INIT:
                if (cnt == 16'(`FPC_INIT_CYC - 1))
                    next_state = DV_USER;
            DV_USER:
                next_state = DV_USER;
            DV_ERROR:
                next_state = DV_ERROR;
            default:
                next_state = DV_POR;
        endcase
        // the power-on delay runs to its end even with the request low
        if (!req_n_s && state != DV_POR)
            next_state = DV_RECONF;
    end

    always_ff @(posedge lnk.config_clock)
    begin
        if (!rst_b)
        begin
            state <= DV_POR;
            cnt   <= 16'h0000;
        end
        else
        begin
            state <= next_state;
            cnt   <= (next_state != state) ? 16'h0000 : cnt + 16'h0001;
        end
    end

    // the width strap is only looked at while no image is in flight
    always_ff @(posedge lnk.config_clock)
    begin
        if (!rst_b)
            width <= FPC_W8;
        else if (state == DV_POR || state == DV_RECONF)
            width <= fpc_width_of(sel_s[1:0]);
    end

    always_ff @(posedge lnk.config_clock)
    begin
        if (!rst_b)
        begin
            opt   <= 3'h0;
            ratio <= 4'h1;
        end
        else if (state == DV_RECONF || state == DV_WAIT)
        begin
            opt   <= 3'h0;
            ratio <= 4'h1;
        end
        else if (state == DV_OPTION)
        begin
            opt   <= beat[2:0];
            ratio <= fpc_ratio(width, beat[`FPC_OPT_COMP], beat[`FPC_OPT_SEC]);
        end
    end

    always_ff @(posedge lnk.config_clock)
    begin
        if (!rst_b)
            ratio_cnt <= 4'h0;
        else if (state != DV_LOAD)
            ratio_cnt <= 4'h0;
        else
            ratio_cnt <= (ratio_cnt == ratio - 4'h1) ? 4'h0 : ratio_cnt + 4'h1;
    end

    // running xor of payload beats; the final beat must equal it
    always_ff @(posedge lnk.config_clock)
    begin
        if (!rst_b)
        begin
            beat_cnt <= 16'h0000;
            csum     <= 32'h0000_0000;
        end
        else if (state != DV_LOAD)
        begin
            beat_cnt <= 16'h0000;
            csum     <= 32'h0000_0000;
        end
        else if (take && !last_beat)
        begin
            beat_cnt <= beat_cnt + 16'h0001;
            csum     <= csum ^ beat;
        end
    end

    always_ff @(posedge lnk.config_clock)
    begin
        if (!rst_b)
        begin
            user_data    <= 32'h0000_0000;
            config_error <= 1'b0;
        end
        else
        begin
            user_data    <= in_user ? lnk.data : 32'h0000_0000;
            config_error <= (next_state == DV_ERROR);
        end
    end

    assign user_mode            = in_user;
    assign init_done_en         = opt[`FPC_OPT_INIT];
    assign lnk.status_o         = 1'b0;
    assign lnk.status_oe        = (state == DV_POR) || (state == DV_RECONF) ||
                                  (state == DV_ERROR);
    assign lnk.load_complete_o  = 1'b0;
    assign lnk.load_complete_oe = !released;
    assign lnk.init_done_o      = 1'b0;
    assign lnk.init_done_oe     = opt[`FPC_OPT_INIT] && init_busy;
endmodule

// >>> rtl/fpc_cfg.svh
`ifndef FPC_CFG_SVH
`define FPC_CFG_SVH

`define FPC_SYS_PERIOD_NS   25
`define FPC_CLK_HALF        1
`define FPC_LINK_PERIOD_NS  (2 * `FPC_CLK_HALF * `FPC_SYS_PERIOD_NS)

`define FPC_POR_SHORT_NS    100000
`define FPC_POR_LONG_NS     400000
`define FPC_POR_SHORT_CYC   ((`FPC_POR_SHORT_NS + `FPC_LINK_PERIOD_NS - 1) / `FPC_LINK_PERIOD_NS)
`define FPC_POR_LONG_CYC    ((`FPC_POR_LONG_NS + `FPC_LINK_PERIOD_NS - 1) / `FPC_LINK_PERIOD_NS)
`define FPC_RECONF_NS       2000
`define FPC_RECONF_CYC      ((`FPC_RECONF_NS + `FPC_SYS_PERIOD_NS - 1) / `FPC_SYS_PERIOD_NS)
`define FPC_INIT_CYC        8

`define FPC_IMAGE_BEATS     16
`define FPC_SYNC_BYTE       8'h5a
`define FPC_OPT_INIT        0
`define FPC_OPT_COMP        1
`define FPC_OPT_SEC         2

`define FPC_CTRL_OFS        12'h000
`define FPC_STAT_OFS        12'h004
`define FPC_DATA_OFS        12'h008
`define FPC_CTRL_START      0
`define FPC_CTRL_COMP       1
`define FPC_CTRL_SEC        2
`define FPC_CTRL_WIDTH      3

`endif

// >>> rtl/fpc_pkg.sv
package fpc_pkg;

    typedef enum logic [1:0] {FPC_W8, FPC_W16, FPC_W32} fpc_width_type;

    typedef enum {DV_POR, DV_RECONF, DV_WAIT, DV_OPTION, DV_LOAD, DV_DONE,
                  DV_RELEASED, DV_INIT, DV_USER, DV_ERROR} fpc_dev_state_type;

    typedef enum {H_IDLE, H_RECONF, H_WAIT, H_STREAM, H_FINISH, H_DONE} fpc_host_state_type;

    function automatic fpc_width_type fpc_width_of(input logic [1:0] code);
        fpc_width_type w;
        w = (code == 2'h0) ? FPC_W8 : (code == 2'h1) ? FPC_W16 : FPC_W32;
        return w;
    endfunction

    // extra clocks per word only exist in the 32-bit scheme
    function automatic logic [3:0] fpc_ratio(input fpc_width_type w, input logic comp,
                                             input logic sec);
        logic [3:0] r;
        r = 4'h1;
        if (w == FPC_W32)
            r = comp ? 4'h8 : (sec ? 4'h4 : 4'h1);
        return r;
    endfunction

    function automatic logic [31:0] fpc_lane_mask(input fpc_width_type w);
        logic [31:0] m;
        m = (w == FPC_W8) ? 32'h0000_00ff : (w == FPC_W16) ? 32'h0000_ffff : 32'hffff_ffff;
        return m;
    endfunction

endpackage

// >>> rtl/fpc_link_if.sv
`timescale 1ns/1ps
interface fpc_link_if;
    logic        config_clock;
    logic        reconfig_request_n;
    logic [31:0] data_o;
    logic        data_oe;
    logic [31:0] data;
    logic        status_o;
    logic        status_oe;
    logic        status_n;
    logic        load_complete_o;
    logic        load_complete_oe;
    logic        load_complete;
    logic        init_done_o;
    logic        init_done_oe;
    logic        init_done_n;

    // open-drain lines float high through their board pull-ups
    assign data          = data_oe ? data_o : 32'h0000_0000;
    assign status_n      = status_oe ? status_o : 1'b1;
    assign load_complete = load_complete_oe ? load_complete_o : 1'b1;
    assign init_done_n   = init_done_oe ? init_done_o : 1'b1;

    modport host_mp
    (
        output config_clock,
        output reconfig_request_n,
        output data_o,
        output data_oe,
        input  status_n,
        input  load_complete,
        input  init_done_n
    );

    modport device_mp
    (
        input  config_clock,
        input  reconfig_request_n,
        input  data,
        output status_o,
        output status_oe,
        output load_complete_o,
        output load_complete_oe,
        output init_done_o,
        output init_done_oe
    );
endinterface

// >>> rtl/fpc_sync3.sv
`timescale 1ns/1ps
module fpc_sync3
#(
    parameter int unsigned    W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
)
(
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;

    // a change is accepted only once the second and third stages agree
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            ff1 <= RST_VAL;
            ff2 <= RST_VAL;
            ff3 <= RST_VAL;
            q   <= RST_VAL;
        end
        else
        begin
            ff1 <= d;
            ff2 <= ff1;
            ff3 <= ff2;
            if (ff2 == ff3)
                q <= ff3;
        end
    end
endmodule

// >>> rtl/fpc_host.sv
`timescale 1ns/1ps
`include "fpc_cfg.svh"
module fpc_host
(
    fpc_link_if.host_mp lnk,
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);
    import fpc_pkg::*;

    fpc_host_state_type hstate;
    fpc_host_state_type next_hstate;
    logic [1:0]  lk_s;
    logic        ctrl_comp;
    logic        ctrl_sec;
    logic [1:0]  ctrl_width;
    logic        pending;
    logic [31:0] pend_data;
    logic [7:0]  cnt;
    logic [3:0]  div_cnt;
    logic        clk_q;
    logic [31:0] data_q;
    logic [3:0]  rem;
    logic [1:0]  beat_idx;
    logic        err;

    fpc_sync3 #(.W(2), .RST_VAL(2'h0)) u_lnk_sync
    (
        .clk   (sys_clk),
        .rst_b (rst_b),
        .d     ({lnk.load_complete, lnk.status_n}),
        .q     (lk_s)
    );

    wire st_s   = lk_s[0];
    wire ld_s   = lk_s[1];
    wire a_ctrl = (paddr == `FPC_CTRL_OFS);
    wire a_stat = (paddr == `FPC_STAT_OFS);
    wire a_data = (paddr == `FPC_DATA_OFS);
    wire access = psel & penable;
    wire wr     = access & pready & pwrite;
    wire start  = wr & a_ctrl & pwdata[`FPC_CTRL_START];
    wire [3:0] ratio_cfg = fpc_ratio(fpc_width_of(ctrl_width), ctrl_comp, ctrl_sec);

    // a data write stalls until the previous word has gone out on the link
    assign pready  = !(a_data & pending);
    assign pslverr = access & !(a_ctrl | a_stat | a_data);

    wire [31:0] stat_word = {26'h000_0000, err, (hstate == H_DONE), pending,
                             (hstate != H_IDLE && hstate != H_DONE), ld_s, st_s};
    wire [31:0] ctrl_word = {27'h000_0000, ctrl_width, ctrl_sec, ctrl_comp, 1'b0};
    wire [31:0] rd_mux    = a_ctrl ? ctrl_word : (a_stat ? stat_word : 32'h0000_0000);

    // the clock halts low in streaming while no word is waiting
    wire tick      = (div_cnt == 4'(`FPC_CLK_HALF - 1));
    wire run       = clk_q | (hstate != H_STREAM) | (rem != 4'h0);
    wire rise      = run & tick & !clk_q;
    wire fall      = run & tick & clk_q;
    wire load_word = (hstate == H_STREAM) & pending & !clk_q & (rem == 4'h0);

    always_comb
    begin
        next_hstate = hstate;
        case (hstate)
            H_IDLE, H_DONE:
                if (start)
                    next_hstate = H_RECONF;
            H_RECONF:
                if (cnt >= 8'(`FPC_RECONF_CYC - 1) && !st_s)
                    next_hstate = H_WAIT;
            H_WAIT:
                if (st_s)
                    next_hstate = H_STREAM;
            H_STREAM:
                if (ld_s)
                    next_hstate = H_FINISH;
                else if (!st_s)
                    next_hstate = H_IDLE;
            H_FINISH:
                if (cnt == 8'h02)
                    next_hstate = H_DONE;
            default:
                next_hstate = H_IDLE;
        endcase
        // a new start abandons whatever image is in flight
        if (start)
            next_hstate = H_RECONF;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            hstate <= H_IDLE;
            cnt    <= 8'h00;
        end
        else
        begin
            hstate <= next_hstate;
            if (next_hstate != hstate)
                cnt <= 8'h00;
            else if (hstate == H_FINISH)
                cnt <= cnt + {7'h00, fall};
            else if (cnt != 8'hff)
                cnt <= cnt + 8'h01;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            ctrl_comp  <= 1'b0;
            ctrl_sec   <= 1'b0;
            ctrl_width <= 2'h0;
            prdata     <= 32'h0000_0000;
        end
        else
        begin
            if (wr & a_ctrl)
            begin
                ctrl_comp  <= pwdata[`FPC_CTRL_COMP];
                ctrl_sec   <= pwdata[`FPC_CTRL_SEC];
                ctrl_width <= pwdata[`FPC_CTRL_WIDTH +: 2];
            end
            if (psel & !penable & !pwrite)
                prdata <= rd_mux;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            pending   <= 1'b0;
            pend_data <= 32'h0000_0000;
            err       <= 1'b0;
        end
        else
        begin
            // a word left over from an abandoned image must not lead the next one
            pending <= (wr & a_data) | (pending & !load_word & !start);
            if (wr & a_data)
                pend_data <= pwdata;
            err <= ((hstate == H_STREAM) & !ld_s & !st_s) | (err & !start);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            div_cnt <= 4'h0;
            clk_q   <= 1'b0;
        end
        else
        begin
            div_cnt <= (!run | tick) ? 4'h0 : div_cnt + 4'h1;
            if (run & tick)
                clk_q <= ~clk_q;
        end
    end

    // sync and option beats go at one clock each, payload at the ratio
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            rem      <= 4'h0;
            beat_idx <= 2'h0;
            data_q   <= 32'h0000_0000;
        end
        else if (hstate != H_STREAM)
        begin
            rem      <= 4'h0;
            beat_idx <= 2'h0;
            data_q   <= 32'h0000_0000;
        end
        else if (load_word)
        begin
            rem      <= (beat_idx == 2'h2) ? ratio_cfg : 4'h1;
            beat_idx <= (beat_idx == 2'h2) ? beat_idx : beat_idx + 2'h1;
            data_q   <= pend_data;
        end
        else if (rise & (rem != 4'h0))
            rem <= rem - 4'h1;
    end

    assign lnk.config_clock       = clk_q;
    assign lnk.reconfig_request_n = (hstate != H_RECONF);
    assign lnk.data_o             = data_q;
    assign lnk.data_oe            = (hstate == H_WAIT) || (hstate == H_STREAM);
endmodule

// >>> tb/fpc_link_properties.sv
`timescale 1ns/1ps
module fpc_link_properties
#(
    parameter int unsigned POR_SHORT_CYC = 20
)
(
    input wire logic config_clock,
    input wire logic rst_b,
    input wire logic reconfig_request_n,
    input wire logic status_n,
    input wire logic load_complete,
    input wire logic init_done_n
);
    logic [15:0] por_cnt;
    logic        por_phase;

    // counts link clocks from reset release until status is first seen released
    always_ff @(posedge config_clock)
    begin
        if (!rst_b)
        begin
            por_cnt   <= 16'h0000;
            por_phase <= 1'b1;
        end
        else if (por_phase)
        begin
            por_cnt   <= por_cnt + 16'h0001;
            por_phase <= !status_n;
        end
    end

    default clocking cb @(posedge config_clock); endclocking
    default disable iff (!rst_b);

    a_reset_holds_lines: assert property ($rose(rst_b) |->
        (!status_n && !load_complete) [*8])
        else $error("status or load complete released right after reset");
    a_por_status_low: assert property (por_phase && status_n |->
        32'(por_cnt) >= POR_SHORT_CYC)
        else $error("status released before the power-on delay ran out");
    a_request_pulse_len: assert property ($fell(reconfig_request_n) |->
        !reconfig_request_n [*8])
        else $error("reconfiguration request pulse too short");
    a_request_pulls_status: assert property ($fell(reconfig_request_n) |->
        ##[1:6] !status_n)
        else $error("status not pulled low after reconfiguration request");
    a_abort_drops_done: assert property ($fell(reconfig_request_n) |->
        ##[1:6] !load_complete)
        else $error("load complete not dropped after reconfiguration request");
    a_done_stays_high: assert property (load_complete && reconfig_request_n
        ##1 reconfig_request_n |-> load_complete)
        else $error("load complete fell without reconfiguration request");
    a_user_lines_high: assert property (load_complete && reconfig_request_n |->
        status_n)
        else $error("status low while load complete released");
    // an aborted or failed image drops status together with load complete
    a_init_after_done: assert property ($rose(init_done_n) |->
        load_complete == status_n)
        else $error("init done released before load complete");
    a_init_low_span: assert property ($fell(init_done_n) |-> !init_done_n [*8])
        else $error("init done low for fewer than eight clocks");

    c_load_done: cover property ($rose(load_complete));
    c_init_run: cover property ($fell(init_done_n));
    c_reconfig: cover property ($fell(reconfig_request_n));
endmodule

// >>> tb/test_fast_parallel_config_port.sv
`timescale 1ns/1ps
`include "fpc_cfg.svh"
module test_fast_parallel_config_port;
    import fpc_pkg::*;
    localparam int unsigned POR_S = 20;
    localparam int unsigned POR_L = 40;
    logic        sys_clk       = 1'b0;
    logic        rst_b         = 1'b0;
    logic        dev_rst_b     = 1'b0;
    logic        psel          = 1'b0;
    logic        penable       = 1'b0;
    logic        pwrite        = 1'b0;
    logic [11:0] paddr         = 12'h000;
    logic [31:0] pwdata        = 32'h0000_0000;
    logic [2:0]  scheme_select = 3'h0;
    logic [31:0] prdata;
    logic [31:0] user_data;
    logic        pready;
    logic        pslverr;
    logic        user_mode;
    logic        init_done_en;
    logic        config_error;
    logic [31:0] last          = 32'h0000_0000;
    logic [31:0] vals[$];
    int          runs[$];
    int          run           = 0;
    int          rises         = 0;
    int          fail_count    = 0;
    int          cmp_count     = 0;
    int          cyc           = 0;

    fpc_link_if lnk();
    fpc_host i_fpc_host
    (
        .lnk     (lnk.host_mp),
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr)
    );
    fpc_device #(.POR_SHORT_CYC(POR_S), .POR_LONG_CYC(POR_L)) i_fpc_device
    (
        .lnk           (lnk.device_mp),
        .rst_b         (dev_rst_b),
        .scheme_select (scheme_select),
        .user_mode     (user_mode),
        .user_data     (user_data),
        .init_done_en  (init_done_en),
        .config_error  (config_error)
    );
    fpc_link_properties #(.POR_SHORT_CYC(POR_S)) i_fpc_link_properties
    (
        .config_clock       (lnk.config_clock),
        .rst_b              (dev_rst_b),
        .reconfig_request_n (lnk.reconfig_request_n),
        .status_n           (lnk.status_n),
        .load_complete      (lnk.load_complete),
        .init_done_n        (lnk.init_done_n)
    );

    always #12.5 sys_clk = ~sys_clk;

    // runs of equal samples at rising link edges; the clock halts between words
    always @(posedge lnk.config_clock)
    begin
        rises++;
        if (lnk.data !== last)
        begin
            vals.push_back(last);
            runs.push_back(run);
            last = lnk.data;
            run  = 0;
        end
        run++;
    end

    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            fail_count++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1)
            @(posedge sys_clk);
        q       = prdata;
        e       = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic wait_stat(input int b, output logic [31:0] q);
        logic e;
        int   n;
        n = 0;
        q = 32'h0000_0000;
        while (q[b] !== 1'b1 && n < 2000)
        begin
            apb(1'b0, `FPC_STAT_OFS, 32'h0000_0000, q, e);
            n++;
        end
    endtask

    task automatic do_reset(input logic [2:0] strap);
        int t;
        int r0;
        t             = 0;
        rst_b         <= 1'b0;
        dev_rst_b     <= 1'b0;
        scheme_select <= strap;
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
        // release on a link edge so device and checker agree on the first edge
        repeat (6) @(posedge lnk.config_clock);
        dev_rst_b <= 1'b1;
        @(posedge sys_clk);
        r0 = rises;
        chk("load complete in por", 32'h0, 32'(lnk.load_complete));
        while (lnk.status_n !== 1'b1 && t < 4000)
        begin
            @(posedge sys_clk);
            t++;
        end
        chk("status released", 32'h1, 32'(lnk.status_n));
        chk("por length", 32'h1,
            32'((rises - r0) >= (strap[2] ? POR_L : POR_S) - 1));
    endtask

    // image: sync beat, option beat, fifteen payload beats and their xor
    task automatic load_image(input logic [1:0] w, input logic c, input logic s,
                              input logic bad, input int beats);
        logic [31:0] v;
        vals.delete();
        runs.delete();
        wr(`FPC_CTRL_OFS, {27'h0, w, s, c, 1'b1});
        wr(`FPC_DATA_OFS, {24'h0, `FPC_SYNC_BYTE});
        wr(`FPC_DATA_OFS, {29'h0, s, c, 1'b1});
        for (int k = 0; k < beats; k++)
        begin
            v = (k == 15) ? (bad ? 32'h0000_0000 : 32'h1f1f_1f1f) : {4{8'(16 + k)}};
            wr(`FPC_DATA_OFS, v);
        end
    endtask

    task automatic finish_ok();
        logic [31:0] q;
        int          n;
        n = 0;
        wait_stat(4, q);
        chk("stat after good image", 32'h13, q & 32'h33);
        while (user_mode !== 1'b1 && n < 400)
        begin
            @(posedge sys_clk);
            n++;
        end
        chk("user mode", 32'h1, 32'(user_mode));
        chk("lines high", 32'h7,
            {29'h0, lnk.reconfig_request_n, lnk.status_n, lnk.load_complete});
        chk("init enable and error", 32'h2, {30'h0, init_done_en, config_error});
        repeat (100) @(posedge sys_clk);
        chk("still user mode", 32'h3, {30'h0, user_mode, lnk.load_complete});
    endtask

    task automatic check_runs(input int ratio);
        int i;
        i = 0;
        while (i < vals.size() && vals[i][7:0] !== `FPC_SYNC_BYTE)
            i++;
        chk("beats seen", 32'h1, 32'(i + 17 <= runs.size()));
        if (i + 17 <= runs.size())
        begin
            chk("sync clocks", 32'h1, 32'(runs[i]));
            chk("option clocks", 32'h1, 32'(runs[i + 1]));
            for (int k = 0; k < 15; k++)
                chk("word clocks", 32'(ratio), 32'(runs[i + 2 + k]));
        end
    endtask

    task automatic run_mode(input logic [1:0] w, input logic c, input logic s, input logic lng);
        int ratio;
        ratio = (w == 2'h2) ? (c ? 8 : (s ? 4 : 1)) : 1;
        do_reset({lng, w});
        load_image(w, c, s, 1'b0, 16);
        chk("user data hidden", 32'h0, user_data);
        finish_ok();
        check_runs(ratio);
        $display("test mode w%0d c%0d s%0d done", w, c, s);
    endtask

    task automatic test_bad_and_abort();
        logic [31:0] q;
        logic        e;
        do_reset(3'h0);
        apb(1'b0, 12'hffc, 32'h0000_0000, q, e);
        chk("unmapped read", 32'h1, {q[30:0], e});
        load_image(2'h0, 1'b0, 1'b0, 1'b1, 16);
        wait_stat(5, q);
        chk("stat after bad image", 32'h20, q & 32'h33);
        chk("error output", 32'h1, 32'(config_error));
        load_image(2'h1, 1'b0, 1'b0, 1'b0, 5);
        load_image(2'h1, 1'b0, 1'b0, 1'b0, 16);
        finish_ok();
        $display("test bad image and abort done");
    endtask

    initial
    begin
        @(posedge sys_clk);
        run_mode(2'h0, 1'b0, 1'b0, 1'b0);
        run_mode(2'h1, 1'b0, 1'b0, 1'b1);
        run_mode(2'h2, 1'b0, 1'b0, 1'b0);
        run_mode(2'h2, 1'b0, 1'b1, 1'b0);
        run_mode(2'h2, 1'b1, 1'b0, 1'b0);
        run_mode(2'h2, 1'b1, 1'b1, 1'b0);
        test_bad_and_abort();
        give_verdict();
    end
endmodule
